// ---- core/axbps_axis.sv ----
/*
  One axis: home/motion breakpoints, staged parameters, position-set commands.
  Assumes command strobes are one cycle, and that the profile generator and
  encoder report motion as count steps synchronous to clk.
*/
`timescale 1ns/100ps
module axbps_axis (
  input wire logic clk,
  input wire logic resetn,
  input wire logic armHomeEventBreakpoint,
  input wire logic armMotionDoneBreakpoint,
  input wire logic cancelBreakpoint,
  input wire logic requestHomeCapture,
  input wire logic enableBreakpointAutoUpdate,
  input wire logic disableBreakpointAutoUpdate,
  input wire logic writeTargetPosition,
  input wire logic [31:0] targetPositionData,
  input wire logic writeVelocity,
  input wire logic [31:0] velocityData,
  input wire logic smoothStopCommand,
  input wire logic applyStagedParameters,
  input wire logic applyStagedMultiAxis,
  input wire logic zeroAllPositions,
  input wire logic syncTargetToActual,
  input wire logic loadActualPosition,
  input wire logic [31:0] actualPositionData,
  input wire logic clearStatus,
  input wire logic [15:0] clearStatusMask,
  input wire logic homeSwitch,
  input wire logic motionDone,
  input wire logic axisMoving,
  input wire logic gearingMode,
  input wire logic curveProfileMode,
  input wire logic encoderUp,
  input wire logic encoderDown,
  input wire logic profileUp,
  input wire logic profileDown,
  output logic [31:0] actualPosition,
  output logic [31:0] profiledPosition,
  output logic [31:0] targetPosition,
  output logic [31:0] activeVelocity,
  output logic [31:0] capturePosition,
  output logic [15:0] axisStatus,
  output logic [1:0] breakpointMode,
  output logic autoUpdateEnabled,
  output logic smoothStopStart
);

  // ==========================================================================
  // state
  axbps_pkg::axbps_brk_t brkMode_r, brkMode_nxt;
  logic autoUpd_r, autoUpd_nxt, captArmed_r, captArmed_nxt, homeSwPrev_r;
  logic doneFlag_r, doneFlag_nxt, arrived_r, arrived_nxt, homeCapt_r, homeCapt_nxt;
  logic cmdErr_r, cmdErr_nxt, stagedStop_r, stagedStop_nxt, syncPending_r, syncPending_nxt;
  logic stopStart_r, stopStart_nxt;
  logic [31:0] capture_r, capture_nxt, stagedTarget_r, stagedTarget_nxt;
  logic [31:0] stagedVel_r, stagedVel_nxt, target_r, target_nxt, vel_r, vel_nxt;
  logic brkTrig, applyNow, busy, homeEdge, zeroOk, loadOk, profLoad;
  logic [31:0] profLoadValue, actualPos, profPos;
  logic signed [31:0] tgtIn;

  // ==========================================================================
  // decode
  // gearing always counts as moving, so it blocks zero and load too
  assign busy = axisMoving || gearingMode;
  assign homeEdge = homeSwitch && !homeSwPrev_r;
  assign zeroOk = zeroAllPositions && !busy;
  assign loadOk = loadActualPosition && !busy && !zeroAllPositions;
  assign brkTrig = ((brkMode_r == axbps_pkg::BRK_HOME) && homeCapt_r) ||
                   ((brkMode_r == axbps_pkg::BRK_MOTION) && doneFlag_r);
  assign applyNow = applyStagedParameters || applyStagedMultiAxis ||
                    (brkTrig && autoUpd_r);
  assign tgtIn = targetPositionData;

  // ==========================================================================
  // breakpoint, capture and status flags
  always_comb begin
    brkMode_nxt = brkMode_r;
    if (brkTrig || cancelBreakpoint) begin
      brkMode_nxt = axbps_pkg::BRK_NONE;
    end
    // a fresh arm in the trigger cycle is kept so a quick re-arm is not lost
    if (armHomeEventBreakpoint) begin
      brkMode_nxt = axbps_pkg::BRK_HOME;
    end else if (armMotionDoneBreakpoint) begin
      brkMode_nxt = axbps_pkg::BRK_MOTION;
    end
    autoUpd_nxt = autoUpd_r;
    if (enableBreakpointAutoUpdate) begin
      autoUpd_nxt = 1'b1;
    end else if (disableBreakpointAutoUpdate) begin
      autoUpd_nxt = 1'b0;
    end
    captArmed_nxt = captArmed_r;
    capture_nxt = capture_r;
    if (captArmed_r && homeEdge) begin
      captArmed_nxt = 1'b0;
      capture_nxt = actualPos;
    end
    if (requestHomeCapture) begin
      captArmed_nxt = 1'b1;
    end
    // set wins over a clear arriving in the same cycle
    arrived_nxt = (brkTrig) ||
                  (arrived_r && !(clearStatus && clearStatusMask[axbps_pkg::STS_BRK_ARRIVED]));
    homeCapt_nxt = (captArmed_r && homeEdge) ||
                   (homeCapt_r && !(clearStatus && clearStatusMask[axbps_pkg::STS_HOME_CAPT]));
    doneFlag_nxt = (motionDone && !gearingMode) ||
                   (doneFlag_r && !(clearStatus && clearStatusMask[axbps_pkg::STS_MOTION_DONE]));
    cmdErr_nxt = (zeroAllPositions && busy) || (loadActualPosition && busy) ||
                 (syncTargetToActual && (gearingMode || !curveProfileMode)) ||
                 (cmdErr_r && !(clearStatus && clearStatusMask[axbps_pkg::STS_CMD_ERROR]));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      brkMode_r <= axbps_pkg::BRK_NONE;
      autoUpd_r <= axbps_pkg::AUTO_UPD_RESET;
      captArmed_r <= 1'b0;
      homeSwPrev_r <= 1'b0;
      capture_r <= axbps_pkg::POS_RESET;
      arrived_r <= 1'b0;
      homeCapt_r <= 1'b0;
      doneFlag_r <= 1'b0;
      cmdErr_r <= 1'b0;
    end else begin
      brkMode_r <= brkMode_nxt;
      autoUpd_r <= autoUpd_nxt;
      captArmed_r <= captArmed_nxt;
      homeSwPrev_r <= homeSwitch;
      capture_r <= capture_nxt;
      arrived_r <= arrived_nxt;
      homeCapt_r <= homeCapt_nxt;
      doneFlag_r <= doneFlag_nxt;
      cmdErr_r <= cmdErr_nxt;
    end
  end

  // ==========================================================================
  // staged and active parameters
  always_comb begin
    stagedTarget_nxt = stagedTarget_r;
    if (writeTargetPosition) begin
      if (tgtIn < axbps_pkg::TARGET_MIN) begin
        stagedTarget_nxt = axbps_pkg::TARGET_MIN;
      end else if (tgtIn > axbps_pkg::TARGET_MAX) begin
        stagedTarget_nxt = axbps_pkg::TARGET_MAX;
      end else begin
        stagedTarget_nxt = targetPositionData;
      end
    end
    stagedVel_nxt = writeVelocity ? velocityData : stagedVel_r;
    stagedStop_nxt = stagedStop_r;
    syncPending_nxt = syncPending_r;
    if (applyNow) begin
      stagedStop_nxt = 1'b0;
      syncPending_nxt = 1'b0;
    end
    if (smoothStopCommand) begin
      stagedStop_nxt = 1'b1;
    end
    if (syncTargetToActual && !gearingMode && curveProfileMode) begin
      syncPending_nxt = 1'b1;
    end
    target_nxt = target_r;
    vel_nxt = vel_r;
    stopStart_nxt = 1'b0;
    profLoad = 1'b0;
    profLoadValue = actualPos;
    if (zeroOk) begin
      target_nxt = axbps_pkg::POS_RESET;
    end else if (loadOk) begin
      target_nxt = actualPositionData;
      profLoad = 1'b1;
      profLoadValue = actualPositionData;
    end else if (applyNow) begin
      // staged values reach the profile only here, never on write
      vel_nxt = stagedVel_r;
      stopStart_nxt = stagedStop_r;
      if (syncPending_r) begin
        target_nxt = actualPos;
        profLoad = 1'b1;
      end else begin
        target_nxt = stagedTarget_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stagedTarget_r <= axbps_pkg::POS_RESET;
      stagedVel_r <= axbps_pkg::VEL_RESET;
      stagedStop_r <= 1'b0;
      syncPending_r <= 1'b0;
      target_r <= axbps_pkg::POS_RESET;
      vel_r <= axbps_pkg::VEL_RESET;
      stopStart_r <= 1'b0;
    end else begin
      stagedTarget_r <= stagedTarget_nxt;
      stagedVel_r <= stagedVel_nxt;
      stagedStop_r <= stagedStop_nxt;
      syncPending_r <= syncPending_nxt;
      target_r <= target_nxt;
      vel_r <= vel_nxt;
      stopStart_r <= stopStart_nxt;
    end
  end

  // ==========================================================================
  // position counters
  axbps_pos_counter actualCounter (
    .clk(clk),
    .resetn(resetn),
    .zero(zeroOk),
    .load(loadOk),
    .loadValue(actualPositionData),
    .stepUp(encoderUp),
    .stepDown(encoderDown),
    .value(actualPos)
  );

  axbps_pos_counter profiledCounter (
    .clk(clk),
    .resetn(resetn),
    .zero(zeroOk),
    .load(profLoad),
    .loadValue(profLoadValue),
    .stepUp(profileUp),
    .stepDown(profileDown),
    .value(profPos)
  );

  // ==========================================================================
  // outputs
  always_comb begin
    axisStatus = 16'h0000;
    axisStatus[axbps_pkg::STS_MOTION_DONE] = doneFlag_r;
    axisStatus[axbps_pkg::STS_BRK_ARRIVED] = arrived_r;
    axisStatus[axbps_pkg::STS_HOME_CAPT] = homeCapt_r;
    axisStatus[axbps_pkg::STS_CMD_ERROR] = cmdErr_r;
    axisStatus[axbps_pkg::STS_MOVING] = busy;
    axisStatus[axbps_pkg::STS_HOME_ARMED] = captArmed_r;
  end

  assign actualPosition = actualPos;
  assign profiledPosition = profPos;
  assign targetPosition = target_r;
  assign activeVelocity = vel_r;
  assign capturePosition = capture_r;
  assign breakpointMode = brkMode_r;
  assign autoUpdateEnabled = autoUpd_r;
  assign smoothStopStart = stopStart_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_home_brk_fire: assert property (
    (brkMode_r == axbps_pkg::BRK_HOME) && homeCapt_r |=> arrived_r
  ) else $error("home breakpoint did not fire");
  a_brk_disarm: assert property (
    brkTrig && !armHomeEventBreakpoint && !armMotionDoneBreakpoint
    |=> (brkMode_r == axbps_pkg::BRK_NONE) && !brkTrig
  ) else $error("breakpoint still armed after trigger");
  a_auto_apply: assert property (
    brkTrig && autoUpd_r && !syncPending_r && !zeroOk && !loadOk
    |=> target_r == $past(stagedTarget_r)
  ) else $error("auto update did not apply staged target");
  a_no_auto_apply: assert property (
    brkTrig && !autoUpd_r && !applyStagedParameters && !applyStagedMultiAxis
    && !zeroOk && !loadOk |=> $stable(target_r) && arrived_r
  ) else $error("target changed without auto update");
  a_arrived_set: assert property (
    brkTrig |=> axisStatus[axbps_pkg::STS_BRK_ARRIVED]
  ) else $error("arrived flag not set on trigger");
  a_capture_store: assert property (
    captArmed_r && homeEdge |=> capturePosition == $past(actualPos) && homeCapt_r
  ) else $error("capture position not stored");
  a_target_span: assert property (
    $signed(stagedTarget_r) >= axbps_pkg::TARGET_MIN &&
    $signed(stagedTarget_r) <= axbps_pkg::TARGET_MAX
  ) else $error("staged target out of span");
  a_target_staged: assert property (
    !applyNow && !zeroOk && !loadOk |=> $stable(target_r) && $stable(vel_r)
  ) else $error("active parameter changed without update");
  a_zero_all: assert property (
    zeroOk && !encoderUp && !encoderDown && !profileUp && !profileDown
    |=> actualPos == 32'h00000000 && profPos == 32'h00000000 && target_r == 32'h00000000
  ) else $error("zero command incomplete");
  a_zero_busy: assert property (
    zeroAllPositions && busy && !applyNow |=> $stable(target_r) && cmdErr_r
  ) else $error("zero command not ignored while moving");
  a_sync_apply: assert property (
    syncPending_r && applyNow && !zeroOk && !loadOk && !profileUp && !profileDown
    |=> target_r == $past(actualPos) && profPos == $past(actualPos)
  ) else $error("sync did not copy actual position");
  a_sync_gear: assert property (
    syncTargetToActual && gearingMode && !syncPending_r |=> !syncPending_r
  ) else $error("sync accepted in gearing mode");
  a_load_all: assert property (
    loadOk && !encoderUp && !encoderDown && !profileUp && !profileDown
    |=> actualPos == $past(actualPositionData) && profPos == $past(actualPositionData)
        && target_r == $past(actualPositionData)
  ) else $error("load command incomplete");
  a_load_busy: assert property (
    loadActualPosition && busy && !applyNow && !zeroOk |=> $stable(target_r)
  ) else $error("load command not ignored while moving");
  a_motion_apply: assert property (
    (brkMode_r == axbps_pkg::BRK_MOTION) && doneFlag_r && autoUpd_r && !syncPending_r
    && !zeroOk && !loadOk
    |=> vel_r == $past(stagedVel_r) && target_r == $past(stagedTarget_r)
  ) else $error("motion breakpoint did not apply staged values");
  a_arrived_sticky: assert property (
    arrived_r && !clearStatus |=> arrived_r
  ) else $error("arrived flag dropped without clear");

  c_home_trigger: cover property (
    (brkMode_r == axbps_pkg::BRK_HOME) && homeCapt_r && autoUpd_r && stagedStop_r
  );
  c_motion_trigger: cover property (
    (brkMode_r == axbps_pkg::BRK_MOTION) && doneFlag_r && autoUpd_r
  );
  c_zero_done: cover property (zeroOk);
  c_sync_done: cover property (syncPending_r && applyNow);

endmodule

// ---- core/axbps_pkg.sv ----
/*
  Shared constants and types for the per-axis breakpoint and position-set logic.
  Assumes one controller clock and a host that issues one-cycle command strobes.
*/
package axbps_pkg;

  // ==========================================================================
  // widths and ranges
  localparam int POS_W = 32;
  localparam int STS_W = 16;
  localparam logic signed [31:0] TARGET_MIN = 32'shC0000000;
  localparam logic signed [31:0] TARGET_MAX = 32'sh3FFFFFFF;

  // ==========================================================================
  // axis status word bit positions
  localparam int STS_MOTION_DONE = 0;
  localparam int STS_BRK_ARRIVED = 2;
  localparam int STS_HOME_CAPT = 3;
  localparam int STS_CMD_ERROR = 7;
  localparam int STS_MOVING = 10;
  localparam int STS_HOME_ARMED = 14;

  // ==========================================================================
  // reset values
  localparam logic [31:0] POS_RESET = 32'h00000000;
  localparam logic [31:0] VEL_RESET = 32'h00000000;
  localparam logic AUTO_UPD_RESET = 1'b0;

  // ==========================================================================
  // breakpoint condition selection
  typedef enum logic [1:0] {
    BRK_NONE = 2'b00,
    BRK_HOME = 2'b01,
    BRK_MOTION = 2'b10
  } axbps_brk_t;

endpackage

// ---- core/axbps_pos_counter.sv ----
/*
  One signed position counter: zero, load, or step by one count.
  Assumes zero and load never meet a step the caller wants kept.
*/
`timescale 1ns/100ps
module axbps_pos_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic zero,
  input wire logic load,
  input wire logic [31:0] loadValue,
  input wire logic stepUp,
  input wire logic stepDown,
  output logic [31:0] value
);

  // ==========================================================================
  // next value
  logic [31:0] value_r;
  logic [31:0] value_nxt;

  // zero and load override steps so a set command is never half applied
  always_comb begin
    value_nxt = value_r;
    if (zero) begin
      value_nxt = axbps_pkg::POS_RESET;
    end else if (load) begin
      value_nxt = loadValue;
    end else if (stepUp && !stepDown) begin
      value_nxt = value_r + 32'h00000001;
    end else if (stepDown && !stepUp) begin
      value_nxt = value_r - 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      value_r <= axbps_pkg::POS_RESET;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule

// ---- bench/axbps_far_side.sv ----
/*
  Far-side model of one axis: home switch, motion-done strobe, encoder steps.
  Assumes the bench raises one-cycle requests at the falling edge of clk.
*/
`timescale 1ns/100ps
module axbps_far_side (
  input wire logic clk,
  input wire logic homeReq,
  input wire logic doneReq,
  input wire logic stepReq,
  input wire logic stepDown,
  output logic homeSwitch,
  output logic motionDone,
  output logic encoderUp,
  output logic encoderDown
);
  logic [2:0] pend;
  logic [1:0] homeCnt;

  initial begin
    pend = 3'h0;
    homeCnt = 2'h0;
    homeSwitch = 1'b0;
    motionDone = 1'b0;
    encoderUp = 1'b0;
    encoderDown = 1'b0;
  end

  // ==========================================
  // requests latched on the rising edge
  always @(posedge clk) begin
    pend <= {stepReq, doneReq, homeReq};
  end

  // ==========================================
  // outputs move on the falling edge, away from the design's sampling edge
  always @(negedge clk) begin
    if (pend[0]) begin
      homeCnt <= 2'h2;
    end else if (homeCnt != 2'h0) begin
      homeCnt <= homeCnt - 2'h1;
    end
    // switch held three cycles, then released low
    homeSwitch <= pend[0] | (homeCnt != 2'h0);
    motionDone <= pend[1];
    encoderUp <= pend[2] & ~stepDown;
    encoderDown <= pend[2] & stepDown;
  end
endmodule

// ---- bench/axbps_axis_tb.sv ----
/*
  Self-checking bench for one axis: position commands and breakpoints.
  Assumes the far-side model feeds home, motion-done and encoder steps.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin numErrors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module axbps_axis_tb;
  localparam int ARMH = 0, ARMM = 1, CANCEL = 2, CAPT = 3, AUTON = 4, AUTOFF = 5;
  localparam int WRTGT = 6, WRVEL = 7, STOP = 8, APPLY = 9, MULTI = 10, ZERO = 11;
  localparam int SYNC = 12, LOAD = 13, CLR = 14;
  logic clk, resetn, axisMoving, gearingMode, curveMode, stepDown, stopSeen;
  logic [14:0] cmd;
  logic [2:0] farReq;
  logic [31:0] tgtData, velData, actData;
  logic [15:0] clrMask, axisStatus;
  logic homeSwitch, motionDone, encUp, encDown, autoUpdateEnabled, smoothStopStart;
  logic [31:0] actualPosition, profiledPosition, targetPosition, activeVelocity, capturePosition;
  logic [1:0] breakpointMode;
  logic [31:0] din [4] = '{32'h7FFFFFFF, 32'h80000000, 32'h3FFFFFFF, 32'hC0000000};
  logic [31:0] dex [4] = '{32'h3FFFFFFF, 32'hC0000000, 32'h3FFFFFFF, 32'hC0000000};
  int numErrors, cmpCount;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  axbps_far_side far (.clk(clk), .homeReq(farReq[0]), .doneReq(farReq[1]),
    .stepReq(farReq[2]), .stepDown(stepDown), .homeSwitch(homeSwitch),
    .motionDone(motionDone), .encoderUp(encUp), .encoderDown(encDown));

  axbps_axis dut (.clk(clk), .resetn(resetn), .armHomeEventBreakpoint(cmd[ARMH]),
    .armMotionDoneBreakpoint(cmd[ARMM]), .cancelBreakpoint(cmd[CANCEL]),
    .requestHomeCapture(cmd[CAPT]), .enableBreakpointAutoUpdate(cmd[AUTON]),
    .disableBreakpointAutoUpdate(cmd[AUTOFF]), .writeTargetPosition(cmd[WRTGT]),
    .targetPositionData(tgtData), .writeVelocity(cmd[WRVEL]), .velocityData(velData),
    .smoothStopCommand(cmd[STOP]), .applyStagedParameters(cmd[APPLY]),
    .applyStagedMultiAxis(cmd[MULTI]), .zeroAllPositions(cmd[ZERO]),
    .syncTargetToActual(cmd[SYNC]), .loadActualPosition(cmd[LOAD]),
    .actualPositionData(actData), .clearStatus(cmd[CLR]), .clearStatusMask(clrMask),
    .homeSwitch(homeSwitch), .motionDone(motionDone), .axisMoving(axisMoving),
    .gearingMode(gearingMode), .curveProfileMode(curveMode), .encoderUp(encUp),
    .encoderDown(encDown), .profileUp(1'b0), .profileDown(1'b0),
    .actualPosition(actualPosition), .profiledPosition(profiledPosition),
    .targetPosition(targetPosition), .activeVelocity(activeVelocity),
    .capturePosition(capturePosition), .axisStatus(axisStatus),
    .breakpointMode(breakpointMode), .autoUpdateEnabled(autoUpdateEnabled),
    .smoothStopStart(smoothStopStart));

  // ==========================================
  // one-cycle pulse seen at a rising edge, so a bench flag holds it; a stop strobe clears it
  always @(posedge clk) begin
    if (cmd[STOP] === 1'b1) begin
      stopSeen <= 1'b0;
    end else if (smoothStopStart === 1'b1) begin
      stopSeen <= 1'b1;
    end
  end

  // ==========================================
  // access tasks
  task automatic strobe(input int i);
    cmd[i] = 1'b1;
    @(negedge clk);
    cmd = '0;
    @(negedge clk);
  endtask

  task automatic farPulse(input int i);
    farReq[i] = 1'b1;
    @(negedge clk);
    farReq = '0;
    repeat (6) @(negedge clk);
  endtask

  task automatic clearAll();
    clrMask = 16'hFFFF;
    strobe(CLR);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    $display("ERROR watchdog expected 0 seen 1");
    stop_test();
  end

  // ==========================================
  // test sequence
  initial begin
    numErrors = 0;
    cmpCount = 0;
    resetn = 1'b0;
    cmd = '0;
    farReq = '0;
    {tgtData, velData, actData} = '0;
    clrMask = 16'h0000;
    {axisMoving, gearingMode, curveMode, stepDown} = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    `CHK("targetPosition", 32'h0, targetPosition)
    `CHK("breakpointMode", 2'h0, breakpointMode)
    `CHK("autoUpdateEnabled", 1'b0, autoUpdateEnabled)
    // staged target stays off the active profile until an update
    tgtData = 32'h00004E20;
    strobe(WRTGT);
    `CHK("targetPosition", 32'h0, targetPosition)
    strobe(APPLY);
    `CHK("targetPosition", 32'h00004E20, targetPosition)
    for (int i = 0; i < 4; i++) begin
      tgtData = din[i];
      strobe(WRTGT);
      strobe(i[0] ? MULTI : APPLY);
      `CHK("targetPosition", dex[i], targetPosition)
    end
    actData = 32'h00000100;
    strobe(LOAD);
    `CHK("actualPosition", 32'h100, actualPosition)
    `CHK("targetPosition", 32'h100, targetPosition)
    `CHK("profiledPosition", 32'h100, profiledPosition)
    // moving, then gearing: load and zero both refused
    for (int i = 0; i < 2; i++) begin
      {axisMoving, gearingMode} = i[0] ? 2'b01 : 2'b10;
      actData = 32'h00000200;
      strobe(LOAD);
      `CHK("actualPosition", 32'h100, actualPosition)
      `CHK("axisMoving", 1'b1, axisStatus[axbps_pkg::STS_MOVING])
      strobe(ZERO);
      `CHK("actualPosition", 32'h100, actualPosition)
      `CHK("cmdError", 1'b1, axisStatus[axbps_pkg::STS_CMD_ERROR])
      {axisMoving, gearingMode} = 2'b00;
      clearAll();
    end
    repeat (3) farPulse(2);
    `CHK("actualPosition", 32'h103, actualPosition)
    curveMode = 1'b1;
    strobe(SYNC);
    `CHK("targetPosition", 32'h100, targetPosition)
    strobe(APPLY);
    `CHK("targetPosition", 32'h103, targetPosition)
    `CHK("profiledPosition", 32'h103, profiledPosition)
    // sync refused in gearing and outside curve modes
    for (int i = 0; i < 2; i++) begin
      {gearingMode, curveMode} = i[0] ? 2'b00 : 2'b11;
      strobe(SYNC);
      `CHK("cmdError", 1'b1, axisStatus[axbps_pkg::STS_CMD_ERROR])
      gearingMode = 1'b0;
      clearAll();
    end
    strobe(ZERO);
    `CHK("actualPosition", 32'h0, actualPosition)
    `CHK("targetPosition", 32'h0, targetPosition)
    `CHK("profiledPosition", 32'h0, profiledPosition)
    // motion-done breakpoint with auto update
    velData = 32'h00000004;
    strobe(WRVEL);
    tgtData = 32'h00000020;
    strobe(WRTGT);
    strobe(AUTON);
    `CHK("autoUpdateEnabled", 1'b1, autoUpdateEnabled)
    strobe(ARMM);
    `CHK("breakpointMode", 2'h2, breakpointMode)
    `CHK("activeVelocity", 32'h0, activeVelocity)
    farPulse(1);
    `CHK("motionDone", 1'b1, axisStatus[axbps_pkg::STS_MOTION_DONE])
    `CHK("arrived", 1'b1, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    `CHK("breakpointMode", 2'h0, breakpointMode)
    `CHK("targetPosition", 32'h20, targetPosition)
    `CHK("activeVelocity", 32'h4, activeVelocity)
    repeat (8) @(negedge clk);
    `CHK("arrived", 1'b1, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    clrMask = 16'h0004;
    strobe(CLR);
    `CHK("arrived", 1'b0, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    farPulse(1);
    `CHK("arrived", 1'b0, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    // trigger without auto update leaves the staged target waiting
    strobe(AUTOFF);
    `CHK("autoUpdateEnabled", 1'b0, autoUpdateEnabled)
    clearAll();
    tgtData = 32'h00000030;
    strobe(WRTGT);
    strobe(ARMM);
    `CHK("arrived", 1'b0, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    farPulse(1);
    `CHK("arrived", 1'b1, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    `CHK("targetPosition", 32'h20, targetPosition)
    // cancelled home breakpoint: capture still happens, no trigger
    clearAll();
    repeat (2) farPulse(2);
    strobe(AUTON);
    strobe(CAPT);
    `CHK("captureArmed", 1'b1, axisStatus[axbps_pkg::STS_HOME_ARMED])
    strobe(ARMH);
    `CHK("breakpointMode", 2'h1, breakpointMode)
    strobe(CANCEL);
    `CHK("breakpointMode", 2'h0, breakpointMode)
    farPulse(0);
    `CHK("arrived", 1'b0, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    `CHK("capturePosition", 32'h2, capturePosition)
    // armed home breakpoint with a staged smooth stop
    clearAll();
    strobe(STOP);
    strobe(CAPT);
    strobe(ARMH);
    farPulse(2);
    farPulse(0);
    `CHK("homeCapt", 1'b1, axisStatus[axbps_pkg::STS_HOME_CAPT])
    `CHK("arrived", 1'b1, axisStatus[axbps_pkg::STS_BRK_ARRIVED])
    `CHK("breakpointMode", 2'h0, breakpointMode)
    `CHK("capturePosition", 32'h3, capturePosition)
    `CHK("smoothStopStart", 1'b1, stopSeen)
    `CHK("targetPosition", 32'h30, targetPosition)
    stop_test();
  end
endmodule
